/* pll_fbdiv_pkg.sv */
package pll_fbdiv_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 10; // Serial port address width
  localparam logic [ADDR_W-1:0] FEEDBACK_DIVIDER_CONTROL_ADDR = 10'h016; // Divider control
  localparam logic [ADDR_W-1:0] STATUS_PIN_SELECT_ADDR = 10'h017; // Status pin source
  localparam logic [7:0] FEEDBACK_DIVIDER_CONTROL_RST = 8'h06; // Prescaler code 110
  localparam logic [7:0] STATUS_PIN_SELECT_RST = 8'h00; // Ground level
  localparam logic [7:0] STATUS_PIN_SELECT_WMASK = 8'hfc; // Low two bits read zero

  // ------------------------------------------------------------
  // Field positions in the divider control and status select registers
  // ------------------------------------------------------------
  localparam int unsigned CP_HALF_BIT = 7; // Charge pump output to mid supply
  localparam int unsigned REF_DIV_RESET_BIT = 6; // Reference divider reset
  localparam int unsigned SWALLOW_RESET_BIT = 5; // Swallow and main counter reset
  localparam int unsigned ALL_RESET_BIT = 4; // All counters reset
  localparam int unsigned BYPASS_BIT = 3; // Main feedback counter divide by one
  localparam int unsigned PRESCALER_LSB = 0; // Prescaler code low bit
  localparam int unsigned PRESCALER_W = 3; // Prescaler code width
  localparam int unsigned STATUS_SEL_LSB = 2; // Status select low bit
  localparam int unsigned STATUS_SEL_W = 6; // Status select width
  localparam int unsigned SWALLOW_W = 6; // Swallow count width
  localparam int unsigned RATIO_W = 6; // Prescaler ratio width, up to 33

  // ------------------------------------------------------------
  // Prescaler codes
  // ------------------------------------------------------------
  localparam logic [2:0] PRE_FIXED_1 = 3'h0;
  localparam logic [2:0] PRE_FIXED_2 = 3'h1;
  localparam logic [2:0] PRE_DUAL_2 = 3'h2;
  localparam logic [2:0] PRE_DUAL_4 = 3'h3;
  localparam logic [2:0] PRE_DUAL_8 = 3'h4;
  localparam logic [2:0] PRE_DUAL_16 = 3'h5;
  localparam logic [2:0] PRE_DUAL_32 = 3'h6;
  localparam logic [2:0] PRE_FIXED_3 = 3'h7;

  // ------------------------------------------------------------
  // Status select codes
  // ------------------------------------------------------------
  localparam logic [5:0] SEL_GROUND = 6'h00;
  localparam logic [5:0] SEL_FEEDBACK = 6'h01;
  localparam logic [5:0] SEL_REF_DIV = 6'h02;
  localparam logic [5:0] SEL_SWALLOW = 6'h03;
  localparam logic [5:0] SEL_PRESCALER = 6'h04;
  localparam logic [5:0] SEL_PFD_UP = 6'h05;
  localparam logic [5:0] SEL_PFD_DOWN = 6'h06;
  localparam logic [5:0] SEL_MON_GROUND = 6'h20;
  localparam logic [5:0] SEL_FIRST_REF = 6'h21;
  localparam logic [5:0] SEL_SECOND_REF = 6'h22;
  localparam logic [5:0] SEL_ACTIVE_REF = 6'h23;
  localparam logic [5:0] SEL_IDLE_REF = 6'h24;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  // Signals routed to the status pin or steering its selection, all asynchronous
  typedef struct packed {
    logic feedback_out; // Feedback divider after its delay
    logic ref_div_out; // Reference divider after its delay
    logic swallow_out; // Swallow counter output
    logic prescaler_out; // Prescaler output
    logic pfd_up; // Phase detector up pulse
    logic pfd_down; // Phase detector down pulse
    logic first_reference_input; // First single-ended reference
    logic second_reference_input; // Second single-ended reference
    logic diff_reference; // Differential reference
    logic diff_mode; // Reference input in differential mode
    logic second_ref_active; // Second reference feeds the loop
  } status_src_s;

  localparam int unsigned SRC_W = $bits(status_src_s); // Synchroniser count

  // Controls handed to the counters
  typedef struct packed {
    logic cp_half; // Charge pump held at mid supply
    logic ref_div_reset; // Reference divider held in reset
    logic swallow_reset; // Swallow counter held in reset
    logic main_reset; // Main feedback counter held in reset
    logic main_div_one; // Main feedback counter divides by one
    logic dual_modulus_mode; // Prescaler in dual-modulus operation
    logic [RATIO_W-1:0] prescaler_ratio; // Present prescaler ratio
  } divider_ctrl_s;

endpackage

/* pll_feedback_divider_status_mux.sv */
module pll_feedback_divider_status_mux
  import pll_fbdiv_pkg::*;
#(
  parameter int unsigned SYNC_STAGES = 3 // Pin synchroniser depth
)
(
  input wire logic clk, // 200 MHz clock
  input wire logic rst_b, // Asynchronous reset, active low
  input wire logic clk_en, // Freezes all state while low
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [ADDR_W-1:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  output logic [7:0] reg_rdata_q, // Register read data
  input wire logic status_lock, // Bit 7 of register 0x01d
  input wire logic [SWALLOW_W-1:0] swallow_count, // Swallow counter value
  input wire status_src_s status_src, // Asynchronous status sources
  output divider_ctrl_s divider_ctrl_q, // Counter controls
  output logic status_pin_q // Status pin level
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (SYNC_STAGES != 3)
  begin : g_bad_sync
    $error("SYNC_STAGES must be 3");
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [7:0] fb_ctrl_q; // Feedback divider control
  logic [7:0] status_sel_q; // Status pin select
  logic [STATUS_SEL_W-1:0] sel; // Select field
  logic [PRESCALER_W-1:0] pre_code; // Prescaler code field
  logic [SRC_W-1:0] src_raw; // Sources as a flat vector
  logic [SRC_W-1:0] src_filt; // Synchronised and filtered sources
  status_src_s src; // Filtered sources by name
  divider_ctrl_s ctrl_d; // Next counter controls
  logic status_d; // Next status pin level

  assign sel = status_sel_q[STATUS_SEL_LSB +: STATUS_SEL_W];
  assign pre_code = fb_ctrl_q[PRESCALER_LSB +: PRESCALER_W];
  assign src_raw = status_src;
  assign src = status_src_s'(src_filt);

  // Divider control register write
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fb_ctrl_q <= FEEDBACK_DIVIDER_CONTROL_RST;
    end
    else if (clk_en && reg_wr && reg_addr == FEEDBACK_DIVIDER_CONTROL_ADDR)
    begin
      fb_ctrl_q <= reg_wdata;
    end
  end

  // Status select write; refused while the lock bit is set so a pin
  // already in use cannot glitch to a new source mid-flight
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_sel_q <= STATUS_PIN_SELECT_RST;
    end
    else if (clk_en && reg_wr && reg_addr == STATUS_PIN_SELECT_ADDR && !status_lock)
    begin
      status_sel_q <= reg_wdata & STATUS_PIN_SELECT_WMASK;
    end
  end

  // Read data, registered; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata_q <= 8'h00;
    end
    else if (clk_en && reg_rd)
    begin
      case (reg_addr)
        FEEDBACK_DIVIDER_CONTROL_ADDR: reg_rdata_q <= fb_ctrl_q;
        STATUS_PIN_SELECT_ADDR: reg_rdata_q <= status_sel_q;
        default: reg_rdata_q <= 8'h00; // Unmapped
      endcase
    end
  end

  // ------------------------------------------------------------
  // Source synchronisers
  // ------------------------------------------------------------
  // Three flops per source; the filtered level moves only once the
  // second and third flops agree, so one metastable sample is ignored
  for (genvar i = 0; i < SRC_W; i++)
  begin : g_sync
    logic [2:0] stage_q; // Synchroniser chain
    logic filt_q; // Filtered level

    // Chain shift
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        stage_q <= 3'h0;
      end
      else if (clk_en)
      begin
        stage_q <= {stage_q[1:0], src_raw[i]};
      end
    end

    // Agreement filter
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        filt_q <= 1'b0;
      end
      else if (clk_en && stage_q[1] == stage_q[2])
      begin
        filt_q <= stage_q[2];
      end
    end

    assign src_filt[i] = filt_q;
  end

  // ------------------------------------------------------------
  // Counter controls
  // ------------------------------------------------------------
  // Ratio and mode follow the prescaler code and the swallow count
  always_comb
  begin
    ctrl_d = '0;
    ctrl_d.cp_half = fb_ctrl_q[CP_HALF_BIT];
    ctrl_d.ref_div_reset = fb_ctrl_q[ALL_RESET_BIT] | fb_ctrl_q[REF_DIV_RESET_BIT];
    ctrl_d.swallow_reset = fb_ctrl_q[ALL_RESET_BIT] | fb_ctrl_q[SWALLOW_RESET_BIT];
    ctrl_d.main_reset = fb_ctrl_q[ALL_RESET_BIT] | fb_ctrl_q[SWALLOW_RESET_BIT];
    ctrl_d.main_div_one = fb_ctrl_q[BYPASS_BIT];
    ctrl_d.dual_modulus_mode = 1'b1;
    // A zero swallow count picks the lower modulus; software keeps it
    // zero under bypass so the prescaler alone sets the ratio
    case (pre_code)
      PRE_FIXED_1:
      begin
        ctrl_d.dual_modulus_mode = 1'b0;
        ctrl_d.prescaler_ratio = 6'h01;
      end
      PRE_FIXED_2:
      begin
        ctrl_d.dual_modulus_mode = 1'b0;
        ctrl_d.prescaler_ratio = 6'h02;
      end
      PRE_DUAL_2: ctrl_d.prescaler_ratio = (swallow_count != '0) ? 6'h03 : 6'h02;
      PRE_DUAL_4: ctrl_d.prescaler_ratio = (swallow_count != '0) ? 6'h05 : 6'h04;
      PRE_DUAL_8: ctrl_d.prescaler_ratio = (swallow_count != '0) ? 6'h09 : 6'h08;
      PRE_DUAL_16: ctrl_d.prescaler_ratio = (swallow_count != '0) ? 6'h11 : 6'h10;
      PRE_DUAL_32: ctrl_d.prescaler_ratio = (swallow_count != '0) ? 6'h21 : 6'h20;
      default:
      begin
        ctrl_d.dual_modulus_mode = 1'b0;
        ctrl_d.prescaler_ratio = 6'h03;
      end
    endcase
  end

  // Counter control flops
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      divider_ctrl_q <= '0;
    end
    else if (clk_en)
    begin
      divider_ctrl_q <= ctrl_d;
    end
  end

  // ------------------------------------------------------------
  // Status pin selection
  // ------------------------------------------------------------
  // Anything not listed lands on ground, in either half of the map
  always_comb
  begin
    status_d = 1'b0;
    case (sel)
      SEL_GROUND: status_d = 1'b0;
      SEL_FEEDBACK: status_d = src.feedback_out;
      SEL_REF_DIV: status_d = src.ref_div_out;
      SEL_SWALLOW: status_d = src.swallow_out;
      SEL_PRESCALER: status_d = src.prescaler_out;
      SEL_PFD_UP: status_d = src.pfd_up;
      SEL_PFD_DOWN: status_d = src.pfd_down;
      SEL_MON_GROUND: status_d = 1'b0;
      SEL_FIRST_REF:
      begin
        status_d = src.diff_mode ? src.diff_reference : src.first_reference_input;
      end
      SEL_SECOND_REF: status_d = src.second_reference_input;
      SEL_ACTIVE_REF:
      begin
        if (src.diff_mode)
        begin
          status_d = src.diff_reference;
        end
        else
        begin
          status_d = src.second_ref_active ? src.second_reference_input
                                           : src.first_reference_input;
        end
      end
      SEL_IDLE_REF:
      begin
        if (src.diff_mode)
        begin
          status_d = 1'b0; // Not available
        end
        else
        begin
          status_d = src.second_ref_active ? src.first_reference_input
                                           : src.second_reference_input;
        end
      end
      default: status_d = 1'b0;
    endcase
  end

  // Status pin flop
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      status_pin_q <= 1'b0;
    end
    else if (clk_en)
    begin
      status_pin_q <= status_d;
    end
  end

endmodule // pll_feedback_divider_status_mux

/* pll_fbdiv_props.sv */
module pll_fbdiv_props
  import pll_fbdiv_pkg::*;
#(
  parameter int unsigned SYNC_STAGES = 3 // Pin synchroniser depth
)
(
  input wire logic clk, // Clock
  input wire logic rst_b, // Reset, active low
  input wire logic clk_en, // Run enable
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [ADDR_W-1:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic [7:0] reg_rdata_q, // Read data
  input wire logic status_lock, // Select lock
  input wire logic [SWALLOW_W-1:0] swallow_count, // Swallow value
  input wire status_src_s status_src, // Pin sources
  input wire divider_ctrl_s divider_ctrl_q, // Counter controls
  input wire logic status_pin_q // Status pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Shadows of the two registers
  // ----
  logic fb_wr; // Taken divider control write
  logic [7:0] fb_q; // Divider control shadow
  logic [5:0] sel_q; // Status select shadow
  logic exp_pin; // Level the select asks for
  assign fb_wr = clk_en && reg_wr && reg_addr == FEEDBACK_DIVIDER_CONTROL_ADDR;
  // Locked select writes must not reach the shadow either
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      sel_q <= 6'h00;
    else if (clk_en && reg_wr && !status_lock && reg_addr == STATUS_PIN_SELECT_ADDR)
      sel_q <= reg_wdata[7:2];
  end
  // Divider control shadow
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      fb_q <= 8'h06;
    else if (fb_wr)
      fb_q <= reg_wdata;
  end
  // Pin decode; unlisted codes ground
  always_comb
  begin
    case (sel_q)
      SEL_FEEDBACK: exp_pin = status_src.feedback_out;
      SEL_REF_DIV: exp_pin = status_src.ref_div_out;
      SEL_SWALLOW: exp_pin = status_src.swallow_out;
      SEL_PRESCALER: exp_pin = status_src.prescaler_out;
      SEL_PFD_UP: exp_pin = status_src.pfd_up;
      SEL_PFD_DOWN: exp_pin = status_src.pfd_down;
      SEL_FIRST_REF: exp_pin = status_src.diff_mode ? status_src.diff_reference :
        status_src.first_reference_input;
      SEL_SECOND_REF: exp_pin = status_src.second_reference_input;
      SEL_ACTIVE_REF: exp_pin = status_src.diff_mode ? status_src.diff_reference :
        status_src.second_ref_active ? status_src.second_reference_input :
        status_src.first_reference_input;
      SEL_IDLE_REF: exp_pin = !status_src.diff_mode && (status_src.second_ref_active ?
        status_src.first_reference_input : status_src.second_reference_input);
      default: exp_pin = 1'b0;
    endcase
  end
  // Prescaler ratio from code and swallow state
  function automatic logic [5:0] ratio_f(logic [2:0] c, logic nz);
    ratio_f = (c inside {[3'h2:3'h6]}) ? (6'h01 << (c - 3'h1)) + {5'h00, nz} :
      (c == 3'h7) ? 6'h03 : {3'h0, c} + 6'h01;
  endfunction
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // A second write one edge later would overlap, so it is excluded
  sequence fb_set;
    fb_wr ##1 (clk_en && !fb_wr);
  endsequence
  all_reset_a: assert property (fb_set |=> !fb_q[4] || (divider_ctrl_q.main_reset &&
    divider_ctrl_q.swallow_reset && divider_ctrl_q.ref_div_reset))
    else $error("counters not held by all reset");
  ref_reset_a: assert property (fb_set |=>
    divider_ctrl_q.ref_div_reset == (fb_q[6] | fb_q[4]))
    else $error("reference divider reset wrong");
  bypass_a: assert property (fb_set |=> divider_ctrl_q.main_div_one == fb_q[3])
    else $error("bypass control wrong");
  ratio_a: assert property (fb_set |=> divider_ctrl_q.prescaler_ratio ==
    ratio_f(fb_q[2:0], $past(swallow_count) != 6'h00))
    else $error("prescaler ratio wrong");
  dual_mode_a: assert property (fb_set |=> divider_ctrl_q.dual_modulus_mode ==
    (fb_q[2:0] inside {[3'h2:3'h6]}))
    else $error("prescaler mode wrong");
  pin_route_a: assert property (
    (clk_en && $stable(status_src) && $stable(sel_q))[*8] |-> status_pin_q == exp_pin)
    else $error("status pin level wrong");
  unmapped_rd_a: assert property (clk_en && reg_rd && reg_addr > STATUS_PIN_SELECT_ADDR |=>
    reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  freeze_a: assert property (!clk_en |=> $stable(divider_ctrl_q) && $stable(reg_rdata_q) &&
    $stable(status_pin_q))
    else $error("state moved while frozen");
endmodule // pll_fbdiv_props

/* test_pll_feedback_divider_status_mux.sv */
module test_pll_feedback_divider_status_mux
  import pll_fbdiv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // Stimulus and tables
  // ----
  logic clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic status_lock = 1'b0; // Select lock level
  logic [ADDR_W-1:0] reg_addr = 10'h000; // Address
  logic [7:0] reg_wdata = 8'h00, reg_rdata_q; // Data
  logic [SWALLOW_W-1:0] swallow_count = 6'h00; // Swallow value
  status_src_s status_src = 11'h000; // Pin sources
  divider_ctrl_s divider_ctrl_q; // Counter controls
  logic status_pin_q; // Status pin
  int fail_count = 0, checks_done = 0;
  // Select, source pattern and expected pin level per entry
  logic [5:0] sel_tab [17] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07, 6'h00,
    6'h20, 6'h21, 6'h21, 6'h22, 6'h23, 6'h23, 6'h23, 6'h24, 6'h24};
  logic [10:0] src_tab [17] = '{11'h400, 11'h200, 11'h100, 11'h080, 11'h040, 11'h020,
    11'h7ff, 11'h7ff, 11'h7ff, 11'h010, 11'h012, 11'h008, 11'h009, 11'h011, 11'h006,
    11'h011, 11'h01a};
  logic [16:0] pin_exp = 17'h0da3f;
  pll_feedback_divider_status_mux #(.SYNC_STAGES(3)) dut_u (.clk(clk), .rst_b(rst_b),
    .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .status_lock(status_lock),
    .swallow_count(swallow_count), .status_src(status_src),
    .divider_ctrl_q(divider_ctrl_q), .status_pin_q(status_pin_q));
  always #2.5 clk = ~clk;
  // ----
  // Access and check tasks
  // ----
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobes rise and fall on falling edges, taken at the rising edge between
  task automatic wr(logic [9:0] a, logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(logic [9:0] a, logic [7:0] exp, string what);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(what, {8'h00, reg_rdata_q}, {8'h00, exp});
  endtask
  function automatic logic [5:0] ratio_of(logic [2:0] c, logic nz);
    ratio_of = (c inside {[3'h2:3'h6]}) ? (6'h01 << (c - 3'h1)) + {5'h00, nz} :
      (c == 3'h7) ? 6'h03 : {3'h0, c} + 6'h01;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----
  // Main sequence
  // ----
  initial
  begin
    repeat (4) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk("reset ratio", {10'h000, divider_ctrl_q.prescaler_ratio}, 16'h0020);
    rd(FEEDBACK_DIVIDER_CONTROL_ADDR, 8'h06, "control reset");
    rd(STATUS_PIN_SELECT_ADDR, 8'h00, "select reset");
    rd(10'h018, 8'h00, "unmapped read");
    $display("test reset done");
    // Bypass only with swallow count zero, as software must
    for (int n = 0; n < 2; n++)
      for (int c = 0; c < 8; c++)
      begin
        swallow_count = n ? 6'h05 : 6'h00;
        wr(FEEDBACK_DIVIDER_CONTROL_ADDR, {4'h0, ~n[0], c[2:0]});
        repeat (2) @(negedge clk);
        chk("ratio", {10'h000, divider_ctrl_q.prescaler_ratio},
          {10'h000, ratio_of(c, n)});
        chk("dual mode", {15'h0, divider_ctrl_q.dual_modulus_mode},
          {15'h0, c inside {[2:6]}});
        chk("bypass", {15'h0, divider_ctrl_q.main_div_one}, {15'h0, ~n[0]});
      end
    wr(FEEDBACK_DIVIDER_CONTROL_ADDR, 8'h90);
    repeat (2) @(negedge clk);
    chk("all reset", {12'h0, divider_ctrl_q[11:8]}, 16'h000f);
    // Swallow reset bit alone holds the swallow and main counters only
    wr(FEEDBACK_DIVIDER_CONTROL_ADDR, 8'h20);
    repeat (2) @(negedge clk);
    chk("swallow reset", {12'h0, divider_ctrl_q[11:8]}, 16'h0003);
    wr(FEEDBACK_DIVIDER_CONTROL_ADDR, 8'h40);
    repeat (2) @(negedge clk);
    chk("ref reset", {12'h0, divider_ctrl_q[11:8]}, 16'h0004);
    rd(FEEDBACK_DIVIDER_CONTROL_ADDR, 8'h40, "control readback");
    $display("test divider done");
    for (int i = 0; i < 17; i++)
    begin
      status_src = src_tab[i];
      wr(STATUS_PIN_SELECT_ADDR, {sel_tab[i], 2'h0});
      repeat (8) @(negedge clk);
      chk("status pin", {15'h0, status_pin_q},
        {15'h0, pin_exp[i]});
    end
    status_lock = 1'b1;
    wr(STATUS_PIN_SELECT_ADDR, 8'hff);
    rd(STATUS_PIN_SELECT_ADDR, 8'h90, "locked select");
    status_lock = 1'b0;
    wr(STATUS_PIN_SELECT_ADDR, 8'h07);
    rd(STATUS_PIN_SELECT_ADDR, 8'h04, "select low bits");
    $display("test status done");
    // A frozen block must drop the write entirely
    clk_en = 1'b0;
    wr(FEEDBACK_DIVIDER_CONTROL_ADDR, 8'h05);
    clk_en = 1'b1;
    rd(FEEDBACK_DIVIDER_CONTROL_ADDR, 8'h40, "frozen write");
    $display("test freeze done");
    test_done();
  end
  // Watchdog in case a sequence hangs
  initial
  begin
    #20us;
    fail_count++;
    test_done();
  end
endmodule // test_pll_feedback_divider_status_mux

bind pll_feedback_divider_status_mux pll_fbdiv_props #(.SYNC_STAGES(SYNC_STAGES)) props_u (
  .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
  .status_lock(status_lock), .swallow_count(swallow_count), .status_src(status_src),
  .divider_ctrl_q(divider_ctrl_q), .status_pin_q(status_pin_q));
